/* File: logic/gas_cfg.svh */
/*
  Constants of the gas alarm sequencer: register offsets, threshold limits,
  reset values and hold times. Assumes a 25 MHz core clock.
*/
`ifndef GAS_CFG_SVH
`define GAS_CFG_SVH

// Register offsets (word addresses on the register port)
`define GAS_ADDR_PRE_ALARM 16'h012C
`define GAS_ADDR_PRE_WARNING 16'h0133
`define GAS_ADDR_WARNING 16'h0134
`define GAS_ADDR_ALARM 16'h0135

// Flag position in each flag register
`define GAS_FLAG_BIT 0

// Threshold limits and reset values in ppm
`define GAS_ALARM_MIN 16'h0096
`define GAS_ALARM_MAX 16'h0320
`define GAS_ALARM_DEF 16'h01F4
`define GAS_WARN_DEF 16'h0096

// Timebase and hold times
`define GAS_CLK_HZ 25000000
`define GAS_CLK_PERIOD_NS 40
`define GAS_ACK_HOLD_S 1
`define GAS_MUTE_HOLD_S 2
`define GAS_WARN_DELAY_S 1
`define GAS_ALARM_DELAY_S 1

`endif

/* File: logic/gas_pkg.sv */
/*
  Types shared by the gas alarm sequencer and its stage channels.
  Assumes gas_cfg.svh supplies the numeric constants.
*/
package gas_pkg;

  // Stage channel states
  typedef enum logic [1:0] {
    GAS_CH_IDLE = 2'b00,
    GAS_CH_PRE = 2'b01,
    GAS_CH_ON = 2'b10,
    GAS_CH_ACK = 2'b11
  } gas_ch_state_t;

  // Indication of one stage channel
  typedef struct packed {
    logic pre;
    logic on;
  } gas_ind_t;

  // Operator button events
  typedef struct packed {
    logic press;
    logic ack;
    logic mute;
  } gas_btn_t;

endpackage : gas_pkg

/* File: logic/gas_stage_channel.sv */
/*
  One stage channel (warning or alarm): delay, latch, acknowledge.
  Assumes one-cycle event inputs and a one-second tick on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module gas_stage_channel
  import gas_pkg::*;
#(
  parameter int unsigned DELAY_S = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Level inputs
  input wire logic above_i,
  input wire logic below_i,
  input wire logic latched_i,
  input wire logic [15:0] mute_duration_i,
  // Events
  input wire logic sec_tick_i,
  input wire gas_btn_t btn_i,
  // Indication
  output gas_ind_t ind_o
);

  localparam logic [15:0] DELAY_CNT = 16'(DELAY_S);

  gas_ch_state_t state;
  logic [15:0] cnt;

  generate
    if (DELAY_S > 16'hFFFF) begin : g_bad
      $error("DELAY_S does not fit the stage counter");
    end
  endgenerate

  // Stage sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= GAS_CH_IDLE;
      cnt <= 16'h0000;
    end else begin
      unique case (state)
        GAS_CH_IDLE: begin
          if (above_i) begin
            state <= GAS_CH_PRE;
            cnt <= 16'h0000;
          end
        end
        GAS_CH_PRE: begin
          if (!above_i) begin
            state <= GAS_CH_IDLE;
          end else if (sec_tick_i) begin
            if (cnt + 16'h0001 >= DELAY_CNT) begin
              state <= GAS_CH_ON;
            end
            cnt <= cnt + 16'h0001;
          end
        end
        GAS_CH_ON: begin
          if (!latched_i) begin
            if (below_i) begin
              state <= GAS_CH_IDLE;
            end
          end else if (btn_i.press && below_i) begin
            state <= GAS_CH_IDLE;
          end else if (btn_i.ack) begin
            state <= GAS_CH_ACK;
            cnt <= mute_duration_i;
          end
        end
        GAS_CH_ACK: begin
          if (cnt == 16'h0000) begin
            state <= above_i ? GAS_CH_ON : GAS_CH_IDLE;
          end else if (sec_tick_i) begin
            cnt <= cnt - 16'h0001;
          end
        end
      endcase
    end
  end

  // Indication straight from state
  assign ind_o.pre = (state == GAS_CH_PRE);
  assign ind_o.on = (state == GAS_CH_ON);

endmodule : gas_stage_channel
`default_nettype wire

/* File: logic/gas_alarm_sequencer.sv */
/*
  Gas alarm sequencer top: thresholds, button timing, timebase, indicator
  and relay drive, flag register read port.
  Assumes gas_conc_i and configuration come from logic on core_clk_i;
  the mute button is an asynchronous pin, high while pressed.
*/
`include "gas_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module gas_alarm_sequencer
  import gas_pkg::*;
#(
  parameter int unsigned CYC_PER_S = `GAS_CLK_HZ,
  parameter int unsigned WARN_DELAY_S = `GAS_WARN_DELAY_S,
  parameter int unsigned ALARM_DELAY_S = `GAS_ALARM_DELAY_S
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Measurement and configuration
  input wire logic [15:0] gas_conc_i,
  input wire logic thr_load_i,
  input wire logic [15:0] warn_thr_i,
  input wire logic [15:0] alarm_thr_i,
  input wire logic warning_reset_mode_i,
  input wire logic alarm_reset_mode_i,
  input wire logic [15:0] mute_duration_i,
  // Operator button pin
  input wire logic mute_button_i,
  // Register read port
  input wire logic rd_en_i,
  input wire logic [15:0] rd_addr_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // Indicators and actuators
  output logic yellow_led_o,
  output logic red_led_o,
  output logic warning_relay_o,
  output logic alarm_relay_o,
  output logic buzzer_o,
  // Stage flags
  output logic pre_warning_indicator_o,
  output logic warning_indicator_o,
  output logic pre_alarm_indicator_o,
  output logic alarm_indicator_o
);

  localparam logic [31:0] HALF_CYC = 32'(CYC_PER_S / 2);
  localparam logic [31:0] ACK_CYC = 32'(`GAS_ACK_HOLD_S * CYC_PER_S);
  localparam logic [31:0] MUTE_CYC = 32'(`GAS_MUTE_HOLD_S * CYC_PER_S);

  generate
    if (CYC_PER_S < 4 || CYC_PER_S > 32'h1000_0000) begin : g_bad
      $error("CYC_PER_S outside the range the timers can serve");
    end
  endgenerate

  logic [15:0] warn_thr;
  logic [15:0] alarm_thr;
  logic [31:0] half_cnt;
  logic half_tick;
  logic sec_phase;
  logic sec_tick;
  logic flash;
  logic btn_meta;
  logic btn_sync;
  logic btn_prev;
  logic [31:0] hold_cnt;
  gas_btn_t btn;
  logic [15:0] mute_cnt;
  logic warn_above;
  logic warn_below;
  logic alarm_above;
  logic alarm_below;
  gas_ind_t warn_ind;
  gas_ind_t alarm_ind;
  logic [15:0] next_rd_data;

  // Threshold store, alarm value range-checked
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      warn_thr <= `GAS_WARN_DEF;
      alarm_thr <= `GAS_ALARM_DEF;
    end else if (thr_load_i) begin
      warn_thr <= warn_thr_i;
      if (alarm_thr_i >= `GAS_ALARM_MIN && alarm_thr_i <= `GAS_ALARM_MAX) begin
        alarm_thr <= alarm_thr_i;
      end
    end
  end

  // Threshold comparison; equal is neither above nor below: it holds idle and on, but ends pre and a finished ack in idle
  assign warn_above = gas_conc_i > warn_thr;
  assign warn_below = gas_conc_i < warn_thr;
  assign alarm_above = gas_conc_i > alarm_thr;
  assign alarm_below = gas_conc_i < alarm_thr;

  // Half-second timebase for flashing and seconds
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      half_cnt <= 32'h0000_0000;
      half_tick <= 1'b0;
    end else if (half_cnt == HALF_CYC - 32'h0000_0001) begin
      half_cnt <= 32'h0000_0000;
      half_tick <= 1'b1;
    end else begin
      half_cnt <= half_cnt + 32'h0000_0001;
      half_tick <= 1'b0;
    end
  end

  // Flash phase and one-second tick
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash <= 1'b0;
      sec_phase <= 1'b0;
    end else if (half_tick) begin
      flash <= ~flash;
      sec_phase <= ~sec_phase;
    end
  end
  assign sec_tick = half_tick & sec_phase;

  // Button synchroniser
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
      btn_prev <= 1'b0;
    end else begin
      btn_meta <= mute_button_i;
      btn_sync <= btn_meta;
      btn_prev <= btn_sync;
    end
  end

  // Hold time of the button, saturating at the mute hold
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_cnt <= 32'h0000_0000;
    end else if (!btn_sync) begin
      hold_cnt <= 32'h0000_0000;
    end else if (hold_cnt < MUTE_CYC) begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end

  // Button events
  assign btn.press = btn_sync & ~btn_prev;
  assign btn.ack = btn_sync && (hold_cnt == ACK_CYC - 32'h0000_0001);
  // Mute event at the two-second hold
  assign btn.mute = btn_sync
    && (hold_cnt == MUTE_CYC - 32'h0000_0001);

  // Buzzer mute timer in seconds, any reset mode
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mute_cnt <= 16'h0000;
    end else if (btn.mute) begin
      mute_cnt <= mute_duration_i;
    end else if (sec_tick && mute_cnt != 16'h0000) begin
      mute_cnt <= mute_cnt - 16'h0001;
    end
  end

  // Warning stage
  gas_stage_channel #(
    .DELAY_S(WARN_DELAY_S)
  ) u_warn (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .above_i(warn_above),
    .below_i(warn_below),
    .latched_i(warning_reset_mode_i),
    .mute_duration_i(mute_duration_i),
    .sec_tick_i(sec_tick),
    .btn_i(btn),
    .ind_o(warn_ind)
  );

  // Alarm stage
  gas_stage_channel #(
    .DELAY_S(ALARM_DELAY_S)
  ) u_alarm (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .above_i(alarm_above),
    .below_i(alarm_below),
    .latched_i(alarm_reset_mode_i),
    .mute_duration_i(mute_duration_i),
    .sec_tick_i(sec_tick),
    .btn_i(btn),
    .ind_o(alarm_ind)
  );

  // Indicator and actuator drive
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      yellow_led_o <= 1'b0;
      red_led_o <= 1'b0;
      warning_relay_o <= 1'b0;
      alarm_relay_o <= 1'b0;
      buzzer_o <= 1'b0;
    end else begin
      yellow_led_o <= warn_ind.on | (warn_ind.pre & flash);
      red_led_o <= alarm_ind.on | (alarm_ind.pre & flash);
      warning_relay_o <= warn_ind.on;
      alarm_relay_o <= alarm_ind.on;
      buzzer_o <= alarm_ind.on && (mute_cnt == 16'h0000);
    end
  end

  // Stage flags; a pre flag stays set while its stage is pre or on, and clears in ack
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_warning_indicator_o <= 1'b0;
      warning_indicator_o <= 1'b0;
      pre_alarm_indicator_o <= 1'b0;
      alarm_indicator_o <= 1'b0;
    end else begin
      pre_warning_indicator_o <= warn_ind.pre | warn_ind.on;
      warning_indicator_o <= warn_ind.on;
      pre_alarm_indicator_o <= alarm_ind.pre | alarm_ind.on;
      alarm_indicator_o <= alarm_ind.on;
    end
  end

  // Flag register decode; unmapped words read zero
  always_comb begin
    next_rd_data = 16'h0000;
    unique case (rd_addr_i)
      `GAS_ADDR_PRE_ALARM: begin
        next_rd_data[`GAS_FLAG_BIT] = pre_alarm_indicator_o;
      end
      `GAS_ADDR_PRE_WARNING: begin
        next_rd_data[`GAS_FLAG_BIT] = pre_warning_indicator_o;
      end
      `GAS_ADDR_WARNING: begin
        next_rd_data[`GAS_FLAG_BIT] = warning_indicator_o;
      end
      `GAS_ADDR_ALARM: begin
        next_rd_data[`GAS_FLAG_BIT] = alarm_indicator_o;
      end
      default: next_rd_data = 16'h0000;
    endcase
  end

  // Register read answer, one cycle after the request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= next_rd_data;
      end
    end
  end

endmodule : gas_alarm_sequencer
`default_nettype wire

/* File: dv/gas_alarm_monitor.sv */
/* Checker of the gas alarm sequencer outputs.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module gas_alarm_monitor (
  // Clock, reset and inputs
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] gas_conc_i,
  input wire logic warning_reset_mode_i,
  input wire logic alarm_reset_mode_i,
  input wire logic rd_en_i,
  input wire logic [15:0] rd_addr_i,
  // Outputs watched
  input wire logic [15:0] rd_data_o,
  input wire logic yellow_led_o,
  input wire logic warning_relay_o,
  input wire logic alarm_relay_o,
  input wire logic buzzer_o,
  input wire logic pre_warning_indicator_o,
  input wire logic warning_indicator_o,
  input wire logic alarm_indicator_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Gas gone for two cycles in automatic mode
  sequence warn_gone;
    (!warning_reset_mode_i && gas_conc_i == 16'h0000) [*2];
  endsequence
  sequence alarm_gone;
    (!alarm_reset_mode_i && gas_conc_i == 16'h0000) [*2];
  endsequence
  warn_relay_a: assert property (warning_relay_o == warning_indicator_o)
    else $error("warning relay differs from flag");
  alarm_relay_a: assert property (alarm_relay_o == alarm_indicator_o)
    else $error("alarm relay differs from flag");
  buzz_alarm_a: assert property (buzzer_o |-> alarm_indicator_o)
    else $error("buzzer without alarm");
  yellow_on_a: assert property (warning_indicator_o |-> yellow_led_o)
    else $error("yellow not steady in warning");
  warn_auto_a: assert property (warn_gone |=> !warning_relay_o)
    else $error("warning relay kept after gas gone");
  alarm_auto_a: assert property (alarm_gone |=> !alarm_relay_o)
    else $error("alarm relay kept after gas gone");
  read_alarm_a: assert property (rd_en_i && rd_addr_i == 16'h0135
    |=> rd_data_o == {15'h0000, $past(alarm_indicator_o)})
    else $error("alarm flag read wrong");
  read_prew_a: assert property (rd_en_i && rd_addr_i == 16'h0133
    |=> rd_data_o == {15'h0000, $past(pre_warning_indicator_o)})
    else $error("pre-warning flag read wrong");
endmodule : gas_alarm_monitor
bind gas_alarm_sequencer gas_alarm_monitor i_mon (.core_clk_i, .rst_i,
  .gas_conc_i, .warning_reset_mode_i, .alarm_reset_mode_i, .rd_en_i,
  .rd_addr_i, .rd_data_o, .yellow_led_o, .warning_relay_o, .alarm_relay_o,
  .buzzer_o, .pre_warning_indicator_o, .warning_indicator_o,
  .alarm_indicator_o);
`default_nettype wire

/* File: dv/gas_button_model.sv */
/* Operator mute button: held for a commanded number of cycles.
   Assumes go_i is a one-cycle request on core_clk_i. */
`timescale 1ns/1ns
`default_nettype none
module gas_button_model (
  // Clock and command
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic [7:0] hold_i,
  // Button pin, pulled low when released
  output logic button_o
);
  logic [7:0] left = 8'h00;
  // Hold counter, button pressed while nonzero
  always_ff @(posedge core_clk_i) begin
    if (go_i) begin
      left <= hold_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign button_o = left != 8'h00;
endmodule : gas_button_model
`default_nettype wire

/* File: dv/gas_alarm_sequencer_bench.sv */
/* Bench of the gas alarm sequencer: stages, thresholds, latch, mute.
   Assumes the button model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module gas_alarm_sequencer_bench;
  logic clk = 1'b0, rst = 1'b1, load = 1'b0, wmode = 1'b0, amode = 1'b0;
  logic rd_en = 1'b0, go = 1'b0, btn, rdv, yl, rl, wr, ar, bz, pw, w, pa, a;
  logic [15:0] gas = 16'h0000, wthr = 16'h0096, athr = 16'h01F4;
  logic [15:0] mdur = 16'h0002, raddr = 16'h0000, rdata;
  logic [7:0] hold = 8'h00;
  int bad_count = 0, tests_run = 0;
  // Clock 25 MHz
  always #20 clk = ~clk;
  gas_alarm_sequencer #(.CYC_PER_S(20), .WARN_DELAY_S(3), .ALARM_DELAY_S(3))
  i_dut (.core_clk_i(clk), .rst_i(rst), .gas_conc_i(gas), .thr_load_i(load),
    .warn_thr_i(wthr), .alarm_thr_i(athr), .warning_reset_mode_i(wmode),
    .alarm_reset_mode_i(amode), .mute_duration_i(mdur), .mute_button_i(btn),
    .rd_en_i(rd_en), .rd_addr_i(raddr), .rd_data_o(rdata), .rd_valid_o(rdv),
    .yellow_led_o(yl), .red_led_o(rl), .warning_relay_o(wr),
    .alarm_relay_o(ar), .buzzer_o(bz), .pre_warning_indicator_o(pw),
    .warning_indicator_o(w), .pre_alarm_indicator_o(pa),
    .alarm_indicator_o(a));
  gas_button_model i_btn (.core_clk_i(clk), .go_i(go), .hold_i(hold),
    .button_o(btn));
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic gas_to(input logic [15:0] v, input int n);
    @(posedge clk);
    gas <= v;
    cyc(n);
  endtask : gas_to
  task automatic st(input logic [8:0] m, input logic [8:0] e);
    chk({7'h00, {yl, rl, wr, ar, bz, pw, w, pa, a} & m}, {7'h00, e});
  endtask : st
  task automatic flash(input logic red);
    logic hi = 1'b0;
    logic lo = 1'b0;
    repeat (16) begin
      cyc(1);
      hi |= red ? rl : yl;
      lo |= !(red ? rl : yl);
    end
    chk({hi, lo}, 16'h0003);
  endtask : flash
  task automatic flags(input logic [4:0] e);
    logic [15:0] ad [5] = '{16'h0133, 16'h0134, 16'h012C, 16'h0135, 16'h0000};
    foreach (ad[i]) begin
      @(posedge clk);
      rd_en <= 1'b1;
      raddr <= ad[i];
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, {15'h0000, e[4 - i]});
      chk(rdv, 1'b1);
    end
  endtask : flags
  task automatic press(input logic [7:0] n);
    @(posedge clk);
    go <= 1'b1;
    hold <= n;
    @(posedge clk);
    go <= 1'b0;
  endtask : press
  task automatic thr(input logic [15:0] wv, av, input logic e);
    @(posedge clk);
    load <= 1'b1;
    wthr <= wv;
    athr <= av;
    @(posedge clk);
    load <= 1'b0;
    cyc(4);
    chk(pa, e);
  endtask : thr
  // Scenarios
  task automatic t_stages;
    gas_to(16'h00C8, 4);
    st(9'h0FF, 9'h008);
    flash(1'b0);
    cyc(70);
    st(9'h1FF, 9'h14C);
    gas_to(16'h0258, 4);
    st(9'h17F, 9'h14E);
    flash(1'b1);
    cyc(70);
    st(9'h1FF, 9'h1FF);
    flags(5'b11110);
    gas_to(16'h0000, 4);
    st(9'h1FF, 9'h000);
    flags(5'b00000);
    $display("stages done");
  endtask : t_stages
  task automatic t_thr;
    gas_to(16'h0258, 0);
    thr(16'h0096, 16'h0384, 1'b1);
    thr(16'h0096, 16'h0320, 1'b0);
    thr(16'h0064, 16'h0095, 1'b0);
    thr(16'h0064, 16'h0096, 1'b1);
    gas_to(16'h0000, 0);
    thr(16'h0096, 16'h01F4, 1'b0);
    $display("thresholds done");
  endtask : t_thr
  task automatic t_latch;
    @(posedge clk);
    wmode <= 1'b1;
    gas_to(16'h00C8, 70);
    chk(wr, 1'b1);
    gas_to(16'h0000, 6);
    chk(wr, 1'b1);
    press(8'h03);
    cyc(8);
    chk(wr, 1'b0);
    gas_to(16'h00C8, 70);
    press(8'h19);
    cyc(32);
    chk(wr, 1'b0);
    cyc(50);
    chk(wr, 1'b1);
    @(posedge clk);
    wmode <= 1'b0;
    press(8'h19);
    cyc(30);
    chk(wr, 1'b1);
    gas_to(16'h0000, 4);
    $display("latch done");
  endtask : t_latch
  task automatic t_mute;
    gas_to(16'h0258, 80);
    chk(bz, 1'b1);
    press(8'h32);
    cyc(46);
    chk({bz, ar}, 16'h0001);
    cyc(60);
    chk(bz, 1'b1);
    gas_to(16'h0000, 4);
    $display("mute done");
  endtask : t_mute
  task automatic report_and_stop;
    $display("Counted %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence after reset
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    flags(5'b00000);
    t_stages;
    t_thr;
    t_latch;
    t_mute;
    report_and_stop;
  end
  // Watchdog, about seven times the expected run
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule : gas_alarm_sequencer_bench
`default_nettype wire
